//--- jlsr_defs.vh
`ifndef JLSR_DEFS_VH
`define JLSR_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define JLSR_IDX_LINK_PAGE 12'h300
`define JLSR_IDX_LANE4 12'h4b4
`define JLSR_IDX_LANE5 12'h4b5
`define JLSR_IDX_ERR_THRESH 12'h4a0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define JLSR_BIT_DISPARITY 7
`define JLSR_BIT_INVALID_SYM 6
`define JLSR_BIT_STRAY_CTRL 5
`define JLSR_BIT_DESKEW 4
`define JLSR_BIT_INIT_ALIGN 3
`define JLSR_BIT_CHECKSUM 2
`define JLSR_BIT_FRAME 1
`define JLSR_BIT_CODEGROUP 0
`define JLSR_PAGE_LSB 0

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define JLSR_NUM_LINKS 2
`define JLSR_PAGE_W 1
`define JLSR_CNT_W 8
`define JLSR_NUM_ERR 3
`define JLSR_BASE_W 5
`define JLSR_RST_STATUS 8'h00
`define JLSR_RST_PAGE 1'h0
`define JLSR_RST_THRESH 8'h10

`endif

//--- jlsr_err_cmp.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Error count against threshold, one comparator per counter
// ----------------------------------------------------------------
module jlsr_err_cmp #(
  parameter NUM = 3,
  parameter CW = 8
) (
  input wire [NUM*CW-1:0] count_i,
  input wire [CW-1:0] threshold_i,
  output wire [NUM-1:0] over_o
);

  genvar g;
  generate
    for (g = 0; g < NUM; g = g + 1) begin : g_cmp
      assign over_o[g] = (count_i[g*CW +: CW] >= threshold_i);
    end
  endgenerate

endmodule // jlsr_err_cmp

//--- jlsr_page_mux.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Picks the status word of the paged link
// ----------------------------------------------------------------
module jlsr_page_mux #(
  parameter NUM_LINKS = 2,
  parameter SEL_W = 1,
  parameter W = 34
) (
  input wire [NUM_LINKS*W-1:0] bus_i,
  input wire [SEL_W-1:0] sel_i,
  output reg [W-1:0] word_o
);

  integer k;

  always @* begin
    word_o = {W{1'b0}};
    for (k = 0; k < NUM_LINKS; k = k + 1) begin
      if (sel_i == k[SEL_W-1:0]) begin
        word_o = bus_i[k*W +: W];
      end
    end
  end

endmodule // jlsr_page_mux

//--- jlsr_lane_status_regs.v
// Function
// - Lane4 bit4 reads deskew achieved
// - Lane4 bit3 reads initial lane alignment
// - Lane4 bit2 reads configuration checksum correct
// - Lane4 bit1 reads frame alignment held
// - Lane4 bit0 reads code-group sync achieved
// - Lane5 bit7 set when disparity count >= threshold
// - Lane5 bit6 set when invalid-symbol count >= threshold
// - Lane5 bit5 set when stray-control count >= threshold
// - Lane5 bit4 reads deskew achieved
// - Lane5 bit3 reads initial lane alignment
// - Lane5 bit2 reads configuration checksum correct
// - All status follows link page select
// - Lane5 bits1,0 read frame, code-group sync
`timescale 1ns/10ps
`include "jlsr_defs.vh"

module jlsr_lane_status_regs #(
  parameter NUM_LINKS = `JLSR_NUM_LINKS,
  parameter PAGE_W = `JLSR_PAGE_W,
  parameter CNT_W = `JLSR_CNT_W
) (
  input wire clk_sys_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire pready_o,
  output wire [31:0] prdata_o,
  output wire pslverr_o,
  // Per-link lane 4 status: {deskew,init_align,checksum,frame,codegroup}
  input wire [NUM_LINKS*`JLSR_BASE_W-1:0] lane4_status_i,
  // Per-link lane 5 status, same order
  input wire [NUM_LINKS*`JLSR_BASE_W-1:0] lane5_status_i,
  // Per-link lane 5 counts: {stray_control,invalid_symbol,disparity}
  input wire [NUM_LINKS*`JLSR_NUM_ERR*CNT_W-1:0] lane5_err_count_i,
  // Currently paged link
  output wire [PAGE_W-1:0] link_page_o
);

  // ----------------------------------------------------------------
  // Local widths
  // ----------------------------------------------------------------
  localparam BW = `JLSR_BASE_W;
  localparam EW = `JLSR_NUM_ERR * CNT_W;
  localparam LW = 2 * BW + EW;

  // ----------------------------------------------------------------
  // Software state
  // ----------------------------------------------------------------
  reg [PAGE_W-1:0] link_page_r;
  reg [PAGE_W-1:0] link_page_nxt;
  reg [CNT_W-1:0] error_threshold_r;
  reg [CNT_W-1:0] error_threshold_nxt;

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  reg [7:0] lane_four_link_health_r;
  reg [7:0] lane_four_link_health_nxt;
  reg [7:0] lane_five_link_health_r;
  reg [7:0] lane_five_link_health_nxt;

  // ----------------------------------------------------------------
  // Bus answer registers
  // ----------------------------------------------------------------
  reg [31:0] prdata_r;
  reg [31:0] prdata_nxt;
  reg pslverr_r;
  reg pslverr_nxt;

  // ----------------------------------------------------------------
  // Pack each link's status into one word for the page mux
  // ----------------------------------------------------------------
  wire [NUM_LINKS*LW-1:0] link_bus;
  wire [LW-1:0] paged_word;

  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g = g + 1) begin : g_pack
      assign link_bus[g*LW +: LW] = {lane5_err_count_i[g*EW +: EW],
                                     lane5_status_i[g*BW +: BW],
                                     lane4_status_i[g*BW +: BW]};
    end
  endgenerate

  jlsr_page_mux #(
    .NUM_LINKS(NUM_LINKS),
    .SEL_W(PAGE_W),
    .W(LW)
  ) u_page_mux (
    .bus_i(link_bus),
    .sel_i(link_page_r),
    .word_o(paged_word)
  );

  wire [BW-1:0] lane4_sel;
  wire [BW-1:0] lane5_sel;
  wire [EW-1:0] lane5_cnt_sel;
  wire [`JLSR_NUM_ERR-1:0] lane5_over;

  assign lane4_sel = paged_word[BW-1:0];
  assign lane5_sel = paged_word[2*BW-1:BW];
  assign lane5_cnt_sel = paged_word[LW-1:2*BW];

  // ----------------------------------------------------------------
  // Error counts against the threshold
  // ----------------------------------------------------------------
  jlsr_err_cmp #(
    .NUM(`JLSR_NUM_ERR),
    .CW(CNT_W)
  ) u_err_cmp (
    .count_i(lane5_cnt_sel),
    .threshold_i(error_threshold_r),
    .over_o(lane5_over)
  );

  // ----------------------------------------------------------------
  // Lane four fields of the paged link
  // ----------------------------------------------------------------
  wire lane4_deskew_ok;
  wire lane4_initial_align_ok;
  wire lane4_checksum_ok;
  wire lane4_frame_lock;
  wire lane4_codegroup_lock;

  assign lane4_deskew_ok = lane4_sel[4];
  assign lane4_initial_align_ok = lane4_sel[3];
  assign lane4_checksum_ok = lane4_sel[2];
  assign lane4_frame_lock = lane4_sel[1];
  assign lane4_codegroup_lock = lane4_sel[0];

  // ----------------------------------------------------------------
  // Lane five fields of the paged link
  // ----------------------------------------------------------------
  wire lane5_disparity_err_flag;
  wire lane5_invalid_symbol_flag;
  wire lane5_stray_control_flag;
  wire lane5_deskew_ok;
  wire lane5_initial_align_ok;
  wire lane5_checksum_ok;
  wire lane5_frame_lock;
  wire lane5_codegroup_lock;

  assign lane5_disparity_err_flag = lane5_over[0];
  assign lane5_invalid_symbol_flag = lane5_over[1];
  assign lane5_stray_control_flag = lane5_over[2];
  assign lane5_deskew_ok = lane5_sel[4];
  assign lane5_initial_align_ok = lane5_sel[3];
  assign lane5_checksum_ok = lane5_sel[2];
  assign lane5_frame_lock = lane5_sel[1];
  assign lane5_codegroup_lock = lane5_sel[0];

  // ----------------------------------------------------------------
  // Status register next values
  // ----------------------------------------------------------------
  always @* begin
    lane_four_link_health_nxt = `JLSR_RST_STATUS;
    lane_four_link_health_nxt[`JLSR_BIT_DESKEW] =
      lane4_deskew_ok;
    lane_four_link_health_nxt[`JLSR_BIT_INIT_ALIGN] =
      lane4_initial_align_ok;
    lane_four_link_health_nxt[`JLSR_BIT_CHECKSUM] =
      lane4_checksum_ok;
    lane_four_link_health_nxt[`JLSR_BIT_FRAME] =
      lane4_frame_lock;
    lane_four_link_health_nxt[`JLSR_BIT_CODEGROUP] =
      lane4_codegroup_lock;
  end

  always @* begin
    lane_five_link_health_nxt = `JLSR_RST_STATUS;
    lane_five_link_health_nxt[`JLSR_BIT_DISPARITY] =
      lane5_disparity_err_flag;
    lane_five_link_health_nxt[`JLSR_BIT_INVALID_SYM] =
      lane5_invalid_symbol_flag;
    lane_five_link_health_nxt[`JLSR_BIT_STRAY_CTRL] =
      lane5_stray_control_flag;
    lane_five_link_health_nxt[`JLSR_BIT_DESKEW] =
      lane5_deskew_ok;
    lane_five_link_health_nxt[`JLSR_BIT_INIT_ALIGN] =
      lane5_initial_align_ok;
    lane_five_link_health_nxt[`JLSR_BIT_CHECKSUM] =
      lane5_checksum_ok;
    lane_five_link_health_nxt[`JLSR_BIT_FRAME] =
      lane5_frame_lock;
    lane_five_link_health_nxt[`JLSR_BIT_CODEGROUP] =
      lane5_codegroup_lock;
  end

  // Status bits are never loaded from the bus
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      lane_four_link_health_r <= `JLSR_RST_STATUS;
      lane_five_link_health_r <= `JLSR_RST_STATUS;
    end else begin
      lane_four_link_health_r <= lane_four_link_health_nxt;
      lane_five_link_health_r <= lane_five_link_health_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup_phase;
  wire access_phase;
  wire aligned;
  wire [11:0] word_idx;
  wire hit_page;
  wire hit_thresh;
  wire hit_lane4;
  wire hit_lane5;
  wire hit_any;
  wire in_window;

  assign setup_phase = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign word_idx = paddr_i[13:2];
  assign hit_page = aligned & (word_idx == `JLSR_IDX_LINK_PAGE);
  assign hit_thresh = aligned & (word_idx == `JLSR_IDX_ERR_THRESH);
  assign hit_lane4 = aligned & (word_idx == `JLSR_IDX_LANE4);
  assign hit_lane5 = aligned & (word_idx == `JLSR_IDX_LANE5);
  // Upper address bits must be clear, else the word index aliases
  assign in_window = (paddr_i[15:14] == 2'h0);
  assign hit_any = in_window &
                   (hit_page | hit_thresh | hit_lane4 | hit_lane5);

  // ----------------------------------------------------------------
  // Writable control registers
  // ----------------------------------------------------------------
  wire wr_take;
  assign wr_take = access_phase & pwrite_i & pstrb_i[0] & hit_any;

  always @* begin
    link_page_nxt = link_page_r;
    error_threshold_nxt = error_threshold_r;
    if (wr_take & hit_page) begin
      link_page_nxt = pwdata_i[`JLSR_PAGE_LSB +: PAGE_W];
    end
    if (wr_take & hit_thresh) begin
      error_threshold_nxt = pwdata_i[CNT_W-1:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      link_page_r <= `JLSR_RST_PAGE;
      error_threshold_r <= `JLSR_RST_THRESH;
    end else begin
      link_page_r <= link_page_nxt;
      error_threshold_r <= error_threshold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data and error, prepared in the setup cycle
  // ----------------------------------------------------------------
  always @* begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup_phase) begin
      prdata_nxt = 32'h00000000;
      pslverr_nxt = ~hit_any;
      if (~pwrite_i & hit_any) begin
        if (hit_page) begin
          prdata_nxt[`JLSR_PAGE_LSB +: PAGE_W] = link_page_r;
        end
        if (hit_thresh) begin
          prdata_nxt[CNT_W-1:0] = error_threshold_r;
        end
        if (hit_lane4) begin
          prdata_nxt[7:0] = lane_four_link_health_r;
        end
        if (hit_lane5) begin
          prdata_nxt[7:0] = lane_five_link_health_r;
        end
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready_o = access_phase;
  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r & access_phase;
  assign link_page_o = link_page_r;

endmodule // jlsr_lane_status_regs

//--- jlsr_lane_status_regs_asserts.sv
`timescale 1ns/10ps
`include "jlsr_defs.vh"
module jlsr_lane_status_regs_asserts #(
  parameter NUM_LINKS = 2,
  parameter PAGE_W = 1,
  parameter CNT_W = 8
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire pready_o,
  input wire [31:0] prdata_o,
  input wire pslverr_o,
  input wire [NUM_LINKS*`JLSR_BASE_W-1:0] lane4_status_i,
  input wire [NUM_LINKS*`JLSR_BASE_W-1:0] lane5_status_i,
  input wire [NUM_LINKS*`JLSR_NUM_ERR*CNT_W-1:0] lane5_err_count_i,
  input wire [PAGE_W-1:0] link_page_o
);
  // ----
  // Helpers
  // ----
  reg r1_r;
  reg r2_r;
  reg [PAGE_W-1:0] p1_r;
  reg [PAGE_W-1:0] p2_r;
  wire acc = psel_i & penable_i;
  wire rd = acc & ~pwrite_i;
  wire pg_wr = acc & pwrite_i & pstrb_i[0] & (paddr_i == 16'h0c00);
  wire map = paddr_i == 16'h0c00 || paddr_i == 16'h12d0 ||
    paddr_i == 16'h12d4 || paddr_i == 16'h1280;
  wire [4:0] l4 = link_page_o[0] ? lane4_status_i[9:5] : lane4_status_i[4:0];
  wire [4:0] l5 = link_page_o[0] ? lane5_status_i[9:5] : lane5_status_i[4:0];
  // No reset and no page change over the status path
  wire calm = !r1_r && !r2_r && link_page_o == p2_r;
  always @(posedge clk_sys_i) begin
    r1_r <= rst_i;
    r2_r <= r1_r;
    p1_r <= link_page_o;
    p2_r <= p1_r;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  rdy_now_a: assert property (pready_o == acc)
    else $error("pready wrong");
  err_unmap_a: assert property (rd && !map |-> pslverr_o && prdata_o == 0)
    else $error("unmapped not refused");
  map_ok_a: assert property (acc && map |-> !pslverr_o)
    else $error("mapped access refused");
  page_wr_a: assert property (pg_wr |=>
    link_page_o == $past(pwdata_i[0])) else $error("page not written");
  page_hold_a: assert property (!$stable(link_page_o) |-> $past(pg_wr))
    else $error("page moved alone");
  l4_read_a: assert property (rd && calm &&
    paddr_i == 16'h12d0 |-> prdata_o == {27'h0, $past(l4, 2)})
    else $error("lane four word wrong");
  l5_read_a: assert property (rd && calm &&
    paddr_i == 16'h12d4 |-> prdata_o[4:0] == $past(l5, 2))
    else $error("lane five low wrong");
  l5_top_a: assert property (rd && paddr_i == 16'h12d4 |->
    prdata_o[31:8] == 24'h0) else $error("lane five upper set");
  rst_zero_a: assert property ($fell(rst_i) |->
    link_page_o == 0 && prdata_o == 0) else $error("not zero after reset");
endmodule // jlsr_lane_status_regs_asserts

bind jlsr_lane_status_regs jlsr_lane_status_regs_asserts #(
  .NUM_LINKS(NUM_LINKS), .PAGE_W(PAGE_W), .CNT_W(CNT_W)
) chk_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .lane4_status_i(lane4_status_i), .lane5_status_i(lane5_status_i),
  .lane5_err_count_i(lane5_err_count_i), .link_page_o(link_page_o)
);

//--- jlsr_tx_model.sv
`timescale 1ns/10ps
// ----
// Far-side lane state, loaded one link at a time
// ----
module jlsr_tx_model (
  input wire clk_sys_i,
  input wire ld_i,
  input wire link_i,
  input wire [4:0] l4_i,
  input wire [4:0] l5_i,
  input wire [23:0] cnt_i,
  output reg [9:0] lane4_o = 10'h0,
  output reg [9:0] lane5_o = 10'h0,
  output reg [47:0] cnt_o = 48'h0
);
  always @(posedge clk_sys_i) begin
    if (ld_i) begin
      lane4_o[link_i*5 +: 5] <= l4_i;
      lane5_o[link_i*5 +: 5] <= l5_i;
      cnt_o[link_i*24 +: 24] <= cnt_i;
    end
  end
endmodule // jlsr_tx_model

//--- jlsr_lane_status_regs_tb.sv
`timescale 1ns/10ps
module jlsr_lane_status_regs_tb;
  reg clk_sys_i = 0;
  reg rst_i = 1;
  reg psel = 0, pen = 0, pwr = 0, ld = 0, lk = 0;
  reg [15:0] paddr = 0;
  reg [31:0] pwdata = 0, rv, b;
  reg [3:0] pstrb = 0;
  reg [4:0] m4 = 0, m5 = 0;
  reg [23:0] mc = 0;
  reg [7:0] v;
  reg ev;
  wire pready, perr, page;
  wire [31:0] prdata;
  wire [9:0] l4v, l5v;
  wire [47:0] cv;
  integer error_cnt = 0, checked = 0, cyc = 0, i, k;
  always #5 clk_sys_i = ~clk_sys_i;
  jlsr_lane_status_regs dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(perr), .lane4_status_i(l4v),
    .lane5_status_i(l5v), .lane5_err_count_i(cv), .link_page_o(page));
  jlsr_tx_model tx_u (.clk_sys_i(clk_sys_i), .ld_i(ld), .link_i(lk),
    .l4_i(m4), .l5_i(m5), .cnt_i(mc), .lane4_o(l4v), .lane5_o(l5v),
    .cnt_o(cv));
  // ----
  // Bus and check tasks
  // ----
  task summarize;
    begin
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [15:0] a, input [31:0] d, input [3:0] s);
    begin
      @(posedge clk_sys_i);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys_i);
      pen <= 1;
      @(posedge clk_sys_i);
      while (pready !== 1'b1) @(posedge clk_sys_i);
      rv = prdata;
      ev = perr;
      psel <= 0;
      pen <= 0;
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      apb(0, a, 0, 0);
      chk(rv, e);
    end
  endtask
  task set(input l, input [4:0] a, input [4:0] c, input [23:0] n);
    begin
      @(posedge clk_sys_i);
      ld <= 1;
      lk <= l;
      m4 <= a;
      m5 <= c;
      mc <= n;
      @(posedge clk_sys_i);
      ld <= 0;
      repeat (2) @(posedge clk_sys_i);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_lanes;
    for (i = 0; i < 5; i = i + 1) begin
      b = 32'h1 << i;
      set(0, b[4:0], ~b[4:0], 0);
      rd(16'h12d0, b);
      rd(16'h12d4, b ^ 32'h1f);
    end
  endtask
  task t_thr;
    begin
      apb(1, 16'h1280, 32'h20, 4'hf);
      for (i = 0; i < 3; i = i + 1)
        for (k = 0; k < 3; k = k + 1) begin
          v = k == 0 ? 8'h1f : (k == 1 ? 8'h20 : 8'hff);
          set(0, 0, 0, {16'h0, v} << (8 * i));
          b = v >= 8'h20 ? 32'h80 >> i : 0;
          rd(16'h12d4, b);
        end
    end
  endtask
  task t_page;
    begin
      set(0, 5'h0a, 5'h15, 0);
      set(1, 5'h15, 5'h0a, 24'hffffff);
      apb(1, 16'h0c00, 32'h1, 4'h0);
      @(negedge clk_sys_i);
      chk(page, 0);
      apb(1, 16'h0c00, 32'h1, 4'hf);
      @(negedge clk_sys_i);
      chk(page, 1);
      rd(16'h12d0, 32'h15);
      rd(16'h12d4, 32'hea);
      apb(1, 16'h0c00, 32'h0, 4'hf);
      rd(16'h12d0, 32'h0a);
    end
  endtask
  task t_ro;
    begin
      apb(1, 16'h12d0, 32'hffffffff, 4'hf);
      chk(ev, 0);
      rd(16'h12d0, 32'h0a);
      apb(1, 16'h12d4, 32'h0, 4'hf);
      rd(16'h12d4, 32'h15);
      rd(16'h0010, 0);
      chk(ev, 1);
      rd(16'h12d1, 0);
      chk(ev, 1);
      apb(1, 16'h0c00, 32'h1, 4'hf);
      rst_i <= 1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 0;
      rd(16'h0c00, 0);
      rd(16'h1280, 32'h10);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 0;
    rd(16'h1280, 32'h10);
    t_lanes;
    t_thr;
    t_page;
    t_ro;
    summarize;
  end
endmodule // jlsr_lane_status_regs_tb
